// >>> core/udt_pkg.sv
/*
  Package for the up/down auto-reload timer: widths, reset values, mode encodings,
  the prescale ratio and the carrier structs shared by the timer files.
  Assumes nothing of its surroundings beyond a SystemVerilog tool.
*/
package udt_pkg;

  localparam int unsigned UDT_BYTE_W = 8;
  localparam int unsigned UDT_COUNT_W = 16;
  localparam int unsigned UDT_PRESCALE = 12;
  localparam int unsigned UDT_PRESCALE_W = 4;

  localparam logic [UDT_COUNT_W-1:0] UDT_COUNT_MAX = 16'hFFFF;
  localparam logic [UDT_COUNT_W-1:0] UDT_COUNT_RST = 16'h0000;
  localparam logic [UDT_BYTE_W-1:0] UDT_BYTE_RST = 8'h00;
  localparam logic [UDT_BYTE_W-1:0] UDT_BYTE_ONE = 8'h01;
  localparam logic [UDT_BYTE_W-1:0] UDT_BYTE_MAX = 8'hFF;
  localparam logic [UDT_PRESCALE_W-1:0] UDT_PRESCALE_LAST = 4'hB;
  localparam logic [UDT_PRESCALE_W-1:0] UDT_PRESCALE_ONE = 4'h1;
  localparam logic [UDT_PRESCALE_W-1:0] UDT_PRESCALE_RST = 4'h0;

  typedef enum logic [1:0] {
    UDT_MODE_RELOAD = 2'b00,
    UDT_MODE_CAPTURE = 2'b01,
    UDT_MODE_BAUD = 2'b10
  } udt_mode_t;

  // Control bits as software writes them into the control and mode registers.
  typedef struct packed {
    logic run_control_bit;
    logic count_source_select;
    logic capture_reload_select;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic down_count_enable;
  } udt_ctrl_t;

  // Software write strobes for the counter bytes, reload bytes and flags.
  typedef struct packed {
    logic count_low_we;
    logic count_high_we;
    logic reload_low_we;
    logic reload_high_we;
    logic overflow_flag_we;
    logic direction_toggle_flag_we;
    logic [7:0] wdata;
    logic flag_wdata;
  } udt_wr_t;

endpackage

// >>> core/udt_prescale.sv
/*
  Divider that turns the oscillator clock into a one-cycle tick every twelfth cycle.
  Assumes a single clock and the asynchronous active-low reset of the timer.
*/
`timescale 1ns/1ns
`default_nettype none
module udt_prescale
  import udt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  output logic tick
);

  logic [UDT_PRESCALE_W-1:0] div_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= UDT_PRESCALE_RST;
    end else if (div_reg == UDT_PRESCALE_LAST) begin
      div_reg <= UDT_PRESCALE_RST;
    end else begin
      div_reg <= div_reg + UDT_PRESCALE_ONE;
    end
  end

  assign tick = (div_reg == UDT_PRESCALE_LAST);

endmodule
`default_nettype wire

// >>> core/udt_edge.sv
/*
  Falling-edge detector for the external count pin, one tick per high-to-low step.
  Assumes the pin is already synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module udt_edge (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic fall
);

  logic last_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Start from the pin's resting high level, so the first fall after reset is a real one.
      last_reg <= 1'b1;
    end else begin
      last_reg <= pin;
    end
  end

  assign fall = last_reg & ~pin;

endmodule
`default_nettype wire

// >>> core/udt_timer.sv
/*
  Sixteen-bit up/down auto-reload timer built from two chained byte counters.
  Assumes synchronous pins, one 250 MHz clock and control bits held by the core.
*/
`timescale 1ns/1ns
`default_nettype none
module udt_timer
  import udt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire udt_ctrl_t ctrl,
  input wire udt_wr_t wr,
  input wire logic idle_mode,
  input wire logic external_count_pin,
  input wire logic direction_input_pin,
  output logic [UDT_BYTE_W-1:0] count_low_byte,
  output logic [UDT_BYTE_W-1:0] count_high_byte,
  output logic [UDT_BYTE_W-1:0] reload_low_register,
  output logic [UDT_BYTE_W-1:0] reload_high_register,
  output logic overflow_flag,
  output logic direction_toggle_flag,
  output logic irq_request,
  output logic [1:0] mode
);

  logic osc_tick;
  logic pin_fall;
  logic count_tick;
  logic reload_mode;
  logic count_down;
  logic [UDT_BYTE_W-1:0] low_reg;
  logic [UDT_BYTE_W-1:0] high_reg;
  logic [UDT_BYTE_W-1:0] low_next;
  logic [UDT_BYTE_W-1:0] high_next;
  logic [UDT_BYTE_W-1:0] rl_low_reg;
  logic [UDT_BYTE_W-1:0] rl_high_reg;
  logic ovf_reg;
  logic tgl_reg;
  logic wrap_up;
  logic wrap_down;
  logic wrap;
  udt_mode_t mode_sel;

  udt_prescale u_prescale (
    .clk(clk),
    .rst_b(rst_b),
    .tick(osc_tick)
  );

  udt_edge u_edge (
    .clk(clk),
    .rst_b(rst_b),
    .pin(external_count_pin),
    .fall(pin_fall)
  );

  // Idle only halts the core; nothing here looks at it, so counting goes on.
  logic idle_unused;
  assign idle_unused = idle_mode;

  always_comb begin
    if (ctrl.receive_clock_select || ctrl.transmit_clock_select) begin
      mode_sel = UDT_MODE_BAUD;
    end else if (ctrl.capture_reload_select) begin
      mode_sel = UDT_MODE_CAPTURE;
    end else begin
      mode_sel = UDT_MODE_RELOAD;
    end
  end

  assign mode = mode_sel;
  assign reload_mode = (mode_sel == UDT_MODE_RELOAD);

  // Baud and capture behaviour are not built here; those modes just hold the count.
  assign count_tick = ctrl.run_control_bit & reload_mode
    & (ctrl.count_source_select ? pin_fall : osc_tick);

  // Without down-count enable the direction pin is ignored and counting is upward.
  assign count_down = ctrl.down_count_enable & ~direction_input_pin;

  assign wrap_up = count_tick & ~count_down
    & (low_reg == UDT_BYTE_MAX) & (high_reg == UDT_BYTE_MAX);
  assign wrap_down = count_tick & count_down
    & (low_reg == rl_low_reg) & (high_reg == rl_high_reg);
  assign wrap = wrap_up | wrap_down;

  always_comb begin
    low_next = low_reg;
    high_next = high_reg;
    if (wrap_up) begin
      low_next = rl_low_reg;
      high_next = rl_high_reg;
    end else if (wrap_down) begin
      low_next = UDT_BYTE_MAX;
      high_next = UDT_BYTE_MAX;
    end else if (count_tick && !count_down) begin
      low_next = low_reg + UDT_BYTE_ONE;
      if (low_reg == UDT_BYTE_MAX) begin
        high_next = high_reg + UDT_BYTE_ONE;
      end
    end else if (count_tick) begin
      low_next = low_reg - UDT_BYTE_ONE;
      if (low_reg == UDT_BYTE_RST) begin
        high_next = high_reg - UDT_BYTE_ONE;
      end
    end
  end

  // A software byte write takes priority over counting in the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_reg <= UDT_BYTE_RST;
      high_reg <= UDT_BYTE_RST;
    end else begin
      low_reg <= wr.count_low_we ? wr.wdata : low_next;
      high_reg <= wr.count_high_we ? wr.wdata : high_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rl_low_reg <= UDT_BYTE_RST;
      rl_high_reg <= UDT_BYTE_RST;
    end else begin
      if (wr.reload_low_we) begin
        rl_low_reg <= wr.wdata;
      end
      if (wr.reload_high_we) begin
        rl_high_reg <= wr.wdata;
      end
    end
  end

  // The hardware set wins over a software clear landing in the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_reg <= 1'b0;
    end else if (wrap) begin
      ovf_reg <= 1'b1;
    end else if (wr.overflow_flag_we) begin
      ovf_reg <= wr.flag_wdata;
    end
  end

  // Toggling only happens in up/down mode; a software write in the same cycle loses.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_reg <= 1'b0;
    end else if (wrap && ctrl.down_count_enable) begin
      tgl_reg <= ~tgl_reg;
    end else if (wr.direction_toggle_flag_we) begin
      tgl_reg <= wr.flag_wdata;
    end
  end

  assign count_low_byte = low_reg;
  assign count_high_byte = high_reg;
  assign reload_low_register = rl_low_reg;
  assign reload_high_register = rl_high_reg;
  assign overflow_flag = ovf_reg;
  assign direction_toggle_flag = tgl_reg;
  // Only the overflow flag requests service; the toggle flag is a plain count bit.
  assign irq_request = ovf_reg;

endmodule
`default_nettype wire

// >>> verif/udt_checker.sv
/* Port assertions for the timer.
   Assumes a bind to udt_timer in a single clock domain. */
`timescale 1ns/1ns
`default_nettype none
module udt_checker
  import udt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire udt_ctrl_t ctrl,
  input wire udt_wr_t wr,
  input wire logic [7:0] count_low_byte,
  input wire logic [7:0] count_high_byte,
  input wire logic [7:0] reload_low_register,
  input wire logic [7:0] reload_high_register,
  input wire logic overflow_flag,
  input wire logic direction_toggle_flag,
  input wire logic irq_request,
  input wire logic [1:0] mode
);
  wire logic [15:0] cnt = {count_high_byte, count_low_byte};
  wire logic [15:0] rld = {reload_high_register, reload_low_register};
  wire logic cw = wr.count_low_we | wr.count_high_we;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_irq_is_flag: assert property (irq_request == overflow_flag)
    else $error("irq differs from flag");
  chk_stop_holds: assert property (!ctrl.run_control_bit && !cw |=> $stable(cnt))
    else $error("count moved while stopped");
  chk_mode_holds: assert property (mode != UDT_MODE_RELOAD && !cw |=> $stable(cnt))
    else $error("count moved outside reload");
  chk_mode_decode: assert property (mode == ((ctrl.receive_clock_select |
    ctrl.transmit_clock_select) ? UDT_MODE_BAUD : ctrl.capture_reload_select ?
    UDT_MODE_CAPTURE : UDT_MODE_RELOAD)) else $error("mode decode wrong");
  chk_flag_sticky: assert property (overflow_flag && !wr.overflow_flag_we |=> overflow_flag)
    else $error("flag cleared by hardware");
  chk_toggle_wrap: assert property ($changed(direction_toggle_flag) &&
    !$past(wr.direction_toggle_flag_we) |-> $past(ctrl.down_count_enable) &&
    (cnt == rld || cnt == 16'hFFFF)) else $error("toggle moved off a wrap");
  chk_wrap_load: assert property ($rose(overflow_flag) && !$past(wr.overflow_flag_we)
    |-> cnt == rld || cnt == 16'hFFFF) else $error("wrap loaded wrong value");
  chk_step_size: assert property ($changed(cnt) && !$past(cw) |-> cnt == $past(cnt) +
    16'h0001 || cnt == $past(cnt) - 16'h0001 || cnt == rld || cnt == 16'hFFFF)
    else $error("count jumped");
  chk_osc_space: assert property (ctrl.run_control_bit && !ctrl.count_source_select &&
    $changed(cnt) && !$past(cw) |=> $stable(cnt) [*8]) else $error("tick too soon");
  cover property ($rose(overflow_flag));
  cover property ($changed(direction_toggle_flag));
  cover property (mode == UDT_MODE_BAUD);
endmodule
`default_nettype wire

// >>> verif/udt_pin_model.sv
/* External count and direction pins.
   Assumes pulse_req is a one-cycle request from the bench. */
`timescale 1ns/1ns
`default_nettype none
module udt_pin_model (
  input wire logic clk,
  input wire logic dir_level,
  input wire logic pulse_req,
  output logic external_count_pin,
  output logic direction_input_pin
);
  logic [1:0] low_reg = 2'h0;
  // The pin rests high, so only commanded falls can be counted.
  always_ff @(posedge clk) begin
    low_reg <= pulse_req ? 2'h2 : (low_reg != 2'h0) ? low_reg - 2'h1 : 2'h0;
  end
  assign external_count_pin = (low_reg == 2'h0);
  assign direction_input_pin = dir_level;
endmodule
`default_nettype wire

// >>> verif/udt_timer_tb_top.sv
/* Directed bench for the timer.
   Assumes udt_timer, udt_pin_model and udt_checker are compiled. */
`timescale 1ns/1ns
`default_nettype none
module udt_timer_tb_top;
  import udt_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  udt_ctrl_t ctrl = '0;
  udt_wr_t wr = '0;
  logic dir_level = 1'b0;
  logic pulse_req = 1'b0;
  logic idle = 1'b0;
  wire logic ext_pin;
  wire logic dir_pin;
  logic [7:0] cl, ch, rl, rh;
  logic ovf, tgl, irq;
  logic [1:0] mode;
  wire logic [15:0] cnt = {ch, cl};
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  udt_pin_model pins (.clk(clk), .dir_level(dir_level), .pulse_req(pulse_req),
    .external_count_pin(ext_pin), .direction_input_pin(dir_pin));
  // Idle is raised for the external-count scenario: counting must not notice it.
  udt_timer uut (.clk(clk), .rst_b(rst_b), .ctrl(ctrl), .wr(wr), .idle_mode(idle),
    .external_count_pin(ext_pin), .direction_input_pin(dir_pin), .count_low_byte(cl),
    .count_high_byte(ch), .reload_low_register(rl), .reload_high_register(rh),
    .overflow_flag(ovf), .direction_toggle_flag(tgl), .irq_request(irq), .mode(mode));
  task automatic print_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input int k, input logic [7:0] d);
    udt_wr_t w;
    w = '0;
    w.wdata = d;
    w.flag_wdata = d[0];
    w[14-k] = 1'b1;
    @(posedge clk) wr <= w;
    @(posedge clk) wr <= '0;
    #1;
  endtask
  task automatic load(input logic [15:0] c, input logic [15:0] r);
    wb(0, c[7:0]);
    wb(1, c[15:8]);
    wb(2, r[7:0]);
    wb(3, r[15:8]);
  endtask
  task automatic setc(input logic [5:0] v);
    @(posedge clk) ctrl <= v;
    #1;
  endtask
  task automatic pulse;
    @(posedge clk) pulse_req <= 1'b1;
    @(posedge clk) pulse_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic wait_chg;
    logic [15:0] old;
    old = cnt;
    for (int i = 0; i < 30 && cnt === old; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_up_timer;
    check("reset count", cnt, 16'h0000);
    load(16'hFFFE, 16'h1234);
    check("reload regs", {rh, rl}, 16'h1234);
    check("mode", 16'(mode), 16'(UDT_MODE_RELOAD));
    setc(6'h20);
    wait_chg;
    check("up count", cnt, 16'hFFFF);
    wait_chg;
    check("reload", cnt, 16'h1234);
    check("irq", 16'(irq), 16'h0001);
    check("toggle", 16'(tgl), 16'h0000);
    setc(6'h11);
    repeat (10) @(posedge clk);
  endtask
  task automatic t_down_ext;
    idle <= 1'b1;
    wb(4, 8'h00);
    check("flag clear", 16'(ovf), 16'h0000);
    load(16'h0100, 16'h00FE);
    setc(6'h31);
    pulse;
    check("borrow", cnt, 16'h00FF);
    pulse;
    check("down", cnt, 16'h00FE);
    pulse;
    check("underflow", cnt, 16'hFFFF);
    check("flag", 16'(ovf), 16'h0001);
    check("toggle", 16'(tgl), 16'h0001);
    @(posedge clk) dir_level <= 1'b1;
    pulse;
    check("overflow", cnt, 16'h00FE);
    check("toggle", 16'(tgl), 16'h0000);
  endtask
  task automatic t_hold;
    idle <= 1'b0;
    setc(6'h11);
    pulse;
    check("stopped", cnt, 16'h00FE);
    setc(6'h38);
    check("mode", 16'(mode), 16'(UDT_MODE_CAPTURE));
    pulse;
    check("capture hold", cnt, 16'h00FE);
    setc(6'h32);
    check("mode", 16'(mode), 16'(UDT_MODE_BAUD));
    check("flag kept", 16'(ovf), 16'h0001);
    wb(4, 8'h00);
    check("irq", 16'(irq), 16'h0000);
    setc(6'h34);
    check("mode", 16'(mode), 16'(UDT_MODE_BAUD));
    pulse;
    check("baud hold", cnt, 16'h00FE);
    wb(5, 8'h01);
    check("toggle write", 16'(tgl), 16'h0001);
    wb(5, 8'h00);
    check("toggle write", 16'(tgl), 16'h0000);
    check("irq", 16'(irq), 16'h0000);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    t_up_timer;
    t_down_ext;
    t_hold;
    print_verdict;
  end
endmodule
bind udt_timer udt_checker chk (.clk(clk), .rst_b(rst_b), .ctrl(ctrl), .wr(wr),
  .count_low_byte(count_low_byte), .count_high_byte(count_high_byte),
  .reload_low_register(reload_low_register), .reload_high_register(reload_high_register),
  .overflow_flag(overflow_flag), .direction_toggle_flag(direction_toggle_flag),
  .irq_request(irq_request), .mode(mode));
`default_nettype wire
